// [common/adc_cfg_cfg.svh]
// Offsets, field positions, reset values and timing counts of the config write path.
// Assumes inclusion by bare name from the design file.
`ifndef ADC_CFG_CFG_SVH
`define ADC_CFG_CFG_SVH
`define CFG_RESET 8'h01
`define SETUP_RESET 8'h82
`define BYTE_MSB 7
`define CFG_SCAN_HI 6
`define CFG_SCAN_LO 5
`define CFG_RB_HI 4
`define CFG_RB_LO 3
`define CFG_CH_HI 2
`define CFG_CH_LO 1
`define CFG_INPUT_TYPE 0
`define SET_REF_SEL1 6
`define SET_REF_PWR 4
`define SET_CLK_SRC 3
`define SET_POLARITY 2
`define SET_RESET_N 1
`define SET_MON_SETUP 0
`define MON_BYTES 4'd13
`define REPEAT_CONV 4'd8
`define HS_CODE 5'h01
`define BIT_BYTE_END 4'h8
`define BIT_ACK_END 4'h9
`define REF_WAKE_MS 10
`define SYS_CLK_KHZ 10000
`endif

// [common/adc_cfg_pkg.sv]
// Types shared by the converter config write path and its surroundings.
// Assumes the constants header sits on the include path.
package adc_cfg_pkg;
  typedef enum logic [1:0] {SCAN_RANGE, SCAN_REPEAT, SCAN_MONITOR, SCAN_SINGLE} scan_mode_e;
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_WRITE, ST_READ, ST_SKIP} bus_state_e;
  typedef struct packed {
    scan_mode_e mode;
    logic [1:0] first_channel;
    logic [1:0] last_channel;
    logic [3:0] repeat_count;
    logic readback_enable;
    logic single_ended;
    logic unipolar;
    logic external_clock;
  } conv_plan_s;
  typedef struct packed {
    logic valid;
    logic [3:0] index;
    logic [7:0] data;
  } mon_write_s;
endpackage

// [src/adc_config_write_control.sv]
// Write path of a four-input converter: two-wire slave, config and setup registers.
// Assumes scl_clk and scl_in carry the same bus clock wire; sda is open drain outside.
`include "adc_cfg_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module adc_config_write_control #(
  parameter logic [6:0] OWN_ADDR = 7'h34,
  parameter int REF_WAKE_CYCLES = `REF_WAKE_MS * `SYS_CLK_KHZ
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic scl_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic conv_done,
  output adc_cfg_pkg::conv_plan_s conv_plan,
  output logic [7:0] setup_reg,
  output adc_cfg_pkg::mon_write_s mon_write,
  output logic int_clear,
  output logic powered_up,
  output logic hs_mode,
  output logic ref_ready
);
  import adc_cfg_pkg::*;

  localparam int CW = $clog2(REF_WAKE_CYCLES + 1);

  if (REF_WAKE_CYCLES < 1) begin : g_chk
    $error("REF_WAKE_CYCLES must be at least one");
  end

  // ----------------------------------------
  // Link domain: bits shift on scl rise
  // ----------------------------------------
  // Shifter only changes on scl rise, so it stands still
  // while the synced scl is low and the system side reads it.
  logic [7:0] link_shift_q;

  always_ff @(posedge scl_clk or posedge sys_rst) begin
    if (sys_rst) begin
      link_shift_q <= 8'h00;
    end else begin
      link_shift_q <= {link_shift_q[6:0], sda_in};
    end
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic scl_m_q, scl_s_q, scl_p_q;
  logic sda_m_q, sda_s_q, sda_p_q;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      {scl_p_q, scl_s_q, scl_m_q} <= 3'h7;
      {sda_p_q, sda_s_q, sda_m_q} <= 3'h7;
    end else if (clk_en) begin
      {scl_p_q, scl_s_q, scl_m_q} <= {scl_s_q, scl_m_q, scl_in};
      {sda_p_q, sda_s_q, sda_m_q} <= {sda_s_q, sda_m_q, sda_in};
    end
  end

  // ----------------------------------------
  // Bus events
  // ----------------------------------------
  // Limitation: 10 MHz sampling gives about three samples
  // per half period at the top high-speed rate.
  wire start_w = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  wire stop_w = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  wire rise_w = scl_s_q & ~scl_p_q;
  wire fall_w = ~scl_s_q & scl_p_q;

  bus_state_e state_q, state_d;
  logic [3:0] bit_q, bit_d;
  logic [3:0] mon_left_q, mon_left_d;
  logic [7:0] cfg_q, cfg_d;
  logic [7:0] setup_q, setup_d;
  logic oe_q, oe_d;
  logic hs_q, hs_d;
  logic hs_pend_q, hs_pend_d;
  logic pwr_q, pwr_d;
  logic clr_q, clr_d;
  mon_write_s mon_q, mon_d;
  conv_plan_s plan_q;

  wire byte_end_w = fall_w & (bit_q == `BIT_BYTE_END);
  wire ack_end_w = fall_w & (bit_q == `BIT_ACK_END);
  wire ack_rise_w = rise_w & (bit_q == `BIT_BYTE_END);
  wire [7:0] rx_byte_w = link_shift_q;
  wire hs_code_w = rx_byte_w[7:3] == `HS_CODE;
  wire own_addr_w = rx_byte_w[7:1] == OWN_ADDR;
  wire is_setup_w = rx_byte_w[`BYTE_MSB];
  wire ext_clk_w = setup_q[`SET_CLK_SRC];
  wire [3:0] mon_index_w = 4'(`MON_BYTES - mon_left_q);

  // ----------------------------------------
  // Bus sequencer and register writes
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    bit_d = bit_q;
    mon_left_d = mon_left_q;
    cfg_d = cfg_q;
    setup_d = setup_q;
    oe_d = oe_q;
    hs_d = hs_q;
    hs_pend_d = hs_pend_q;
    pwr_d = pwr_q;
    clr_d = 1'b0;
    mon_d = '0;
    if (rise_w && state_q != ST_IDLE) begin
      bit_d = 4'(bit_q + 4'h1);
    end
    if (ack_end_w) begin
      bit_d = 4'h0;
      oe_d = 1'b0;
      hs_d = hs_q | hs_pend_q;
      hs_pend_d = 1'b0;
    end
    case (state_q)
      ST_ADDR: begin
        if (byte_end_w) begin
          if (hs_code_w) begin
            hs_pend_d = 1'b1;
            state_d = ST_SKIP;
          end else if (own_addr_w) begin
            oe_d = 1'b1;
            pwr_d = 1'b1;
            state_d = rx_byte_w[0] ? ST_READ : ST_WRITE;
          end else begin
            state_d = ST_SKIP;
          end
        end
      end
      ST_WRITE: begin
        if (byte_end_w) begin
          oe_d = 1'b1;
          if (mon_left_q != 4'h0) begin
            mon_d = '{valid: 1'b1, index: mon_index_w, data: rx_byte_w};
            mon_left_d = 4'(mon_left_q - 4'h1);
          end else if (is_setup_w) begin
            setup_d = rx_byte_w;
            if (!rx_byte_w[`SET_RESET_N]) begin
              cfg_d = `CFG_RESET;
              clr_d = 1'b1;
            end
            if (rx_byte_w[`SET_MON_SETUP]) begin
              mon_left_d = `MON_BYTES;
            end
          end else begin
            cfg_d = rx_byte_w;
          end
        end
      end
      ST_READ: begin
        if (ack_rise_w && sda_s_q) begin
          state_d = ST_SKIP;
          pwr_d = pwr_d & ~ext_clk_w;
        end
      end
      default: ;
    endcase
    pwr_d = pwr_d & ~(~ext_clk_w & conv_done);
    if (start_w) begin
      state_d = ST_ADDR;
      bit_d = 4'h0;
      oe_d = 1'b0;
      mon_left_d = 4'h0;
      pwr_d = pwr_d & ~(ext_clk_w & (state_q != ST_IDLE));
    end
    if (stop_w) begin
      state_d = ST_IDLE;
      bit_d = 4'h0;
      oe_d = 1'b0;
      mon_left_d = 4'h0;
      hs_d = 1'b0;
      hs_pend_d = 1'b0;
      pwr_d = pwr_d & ~ext_clk_w;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      bit_q <= 4'h0;
      mon_left_q <= 4'h0;
      cfg_q <= `CFG_RESET;
      setup_q <= `SETUP_RESET;
      oe_q <= 1'b0;
      hs_q <= 1'b0;
      hs_pend_q <= 1'b0;
      pwr_q <= 1'b0;
      clr_q <= 1'b0;
      mon_q <= '0;
    end else if (clk_en) begin
      state_q <= state_d;
      bit_q <= bit_d;
      mon_left_q <= mon_left_d;
      cfg_q <= cfg_d;
      setup_q <= setup_d;
      oe_q <= oe_d;
      hs_q <= hs_d;
      hs_pend_q <= hs_pend_d;
      pwr_q <= pwr_d;
      clr_q <= clr_d;
      mon_q <= mon_d;
    end
  end

  // ----------------------------------------
  // Conversion plan decode
  // ----------------------------------------
  wire scan_mode_e mode_w = scan_mode_e'(cfg_q[`CFG_SCAN_HI:`CFG_SCAN_LO]);
  wire [1:0] ch_w = cfg_q[`CFG_CH_HI:`CFG_CH_LO];
  wire from_zero_w = (mode_w == SCAN_RANGE) || (mode_w == SCAN_MONITOR);
  wire se_w = cfg_q[`CFG_INPUT_TYPE];
  conv_plan_s plan_w;

  always_comb begin
    plan_w.mode = mode_w;
    plan_w.first_channel = from_zero_w ? 2'h0 : ch_w;
    plan_w.last_channel = ch_w;
    plan_w.repeat_count = (mode_w == SCAN_REPEAT) ? `REPEAT_CONV : 4'h1;
    plan_w.readback_enable = cfg_q[`CFG_RB_HI] & cfg_q[`CFG_RB_LO];
    plan_w.single_ended = se_w;
    plan_w.unipolar = se_w | ~setup_q[`SET_POLARITY];
    plan_w.external_clock = ext_clk_w;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      plan_q <= '0;
    end else if (clk_en) begin
      plan_q <= plan_w;
    end
  end

  // ----------------------------------------
  // Internal reference wake timer
  // ----------------------------------------
  // Reference runs when selected and either kept on or the part is awake.
  logic [CW-1:0] ref_cnt_q;
  wire ref_on_w = setup_q[`SET_REF_SEL1] & (setup_q[`SET_REF_PWR] | pwr_q);
  wire ref_done_w = ref_cnt_q == CW'(REF_WAKE_CYCLES);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_cnt_q <= '0;
    end else if (clk_en) begin
      if (!ref_on_w) begin
        ref_cnt_q <= '0;
      end else if (!ref_done_w) begin
        ref_cnt_q <= CW'(ref_cnt_q + 1'b1);
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign sda_out = 1'b0;
  assign sda_oe = oe_q;
  assign conv_plan = plan_q;
  assign setup_reg = setup_q;
  assign mon_write = mon_q;
  assign int_clear = clr_q;
  assign powered_up = pwr_q;
  assign hs_mode = hs_q;
  assign ref_ready = ref_on_w & ref_done_w;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  wire wr_byte_w = clk_en && state_q == ST_WRITE && byte_end_w && mon_left_q == 4'h0;

  sequence s_ack_slot;
    oe_q throughout (!ack_end_w) [*1];
  endsequence

  property p_cfg_msb;
    clk_en && wr_byte_w && !is_setup_w |=> cfg_q[`BYTE_MSB] == 1'b0;
  endproperty
  a_cfg_msb: assert property (p_cfg_msb) else $error("config bit 7 not zero");
  property p_route;
    wr_byte_w |=> (is_setup_w ? setup_q : cfg_q) == $past(rx_byte_w);
  endproperty
  a_route: assert property (p_route) else $error("byte routed wrongly");
  property p_ack_byte;
    clk_en && state_q == ST_WRITE && byte_end_w && !start_w && !stop_w |=> s_ack_slot;
  endproperty
  a_ack_byte: assert property (p_ack_byte) else $error("write byte not acked");
  property p_mon_open;
    wr_byte_w && is_setup_w && rx_byte_w[`SET_MON_SETUP] |=> mon_left_q == `MON_BYTES;
  endproperty
  a_mon_open: assert property (p_mon_open) else $error("monitor bytes not opened");
  property p_stop_fs;
    clk_en && stop_w |=> !hs_q && state_q == ST_IDLE && mon_left_q == 4'h0;
  endproperty
  a_stop_fs: assert property (p_stop_fs) else $error("stop left high speed");
  property p_hs_nack;
    clk_en && state_q == ST_ADDR && byte_end_w && hs_code_w && !start_w && !stop_w
      |=> !oe_q && hs_pend_q;
  endproperty
  a_hs_nack: assert property (p_hs_nack) else $error("master code acked");
  property p_rst_cfg;
    wr_byte_w && is_setup_w && !rx_byte_w[`SET_RESET_N]
      |=> cfg_q == `CFG_RESET && clr_q ##1 !clr_q || clk_en == 1'b0;
  endproperty
  a_rst_cfg: assert property (p_rst_cfg) else $error("setup reset missed");
  property p_wake;
    clk_en && state_q == ST_ADDR && byte_end_w && own_addr_w && !hs_code_w
      && !start_w && !stop_w && (ext_clk_w || !conv_done) |=> pwr_q && oe_q;
  endproperty
  a_wake: assert property (p_wake) else $error("no power up on address");
  property p_int_down;
    clk_en && !ext_clk_w && conv_done && !(state_q == ST_ADDR && byte_end_w)
      |=> !pwr_q;
  endproperty
  a_int_down: assert property (p_int_down) else $error("no power down");
  property p_unipolar;
    plan_q.single_ended |-> plan_q.unipolar;
  endproperty
  a_unipolar: assert property (p_unipolar) else $error("single ended not unipolar");
  property p_ref;
    ref_ready |-> ref_cnt_q == CW'(REF_WAKE_CYCLES) && $past(ref_on_w);
  endproperty
  a_ref: assert property (p_ref) else $error("reference ready too early");

endmodule // adc_config_write_control

`default_nettype wire

// [tb/bus_master_model.sv]
// Two-wire bus master model driving the converter's write path.
// Assumes an open-drain data wire with a pull-up, resolved by the bench.
`timescale 1ns/1ps
`default_nettype none

module bus_master_model (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // ----------------------------------------
  // Link clock, bus clock derived from it
  // ----------------------------------------
  logic link_clk = 1'b0;
  always #6 link_clk = ~link_clk;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Slow half period: the slave syncs the bus into a 100 ns domain
  task automatic half();
    repeat (50) @(posedge link_clk);
  endtask

  // ----------------------------------------
  // Bus conditions
  // ----------------------------------------
  // Works from idle or as a repeated START with the clock low
  task automatic bus_start();
    sda_low <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_low <= 1'b1;
    half();
    scl <= 1'b0;
    half();
  endtask

  task automatic bus_stop();
    sda_low <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_low <= 1'b0;
    half();
  endtask

  // MSB first, ack read at the end of the ninth high time
  task automatic write_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low <= ~b[i];
      half();
      scl <= 1'b1;
      half();
      scl <= 1'b0;
    end
    sda_low <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    ack = (sda === 1'b0);
    scl <= 1'b0;
    half();
  endtask
endmodule // bus_master_model

`default_nettype wire

// [tb/tb_adc_config_write_control.sv]
// Self-checking bench of the converter config write path.
// Assumes the package, the constants header and the master model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb_adc_config_write_control;
  import adc_cfg_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic conv_done = 1'b0;
  wire logic scl;
  wire logic sda_low;
  wire logic sda;
  wire logic sda_out;
  wire logic sda_oe;
  conv_plan_s conv_plan;
  logic [7:0] setup_reg;
  mon_write_s mon_write;
  logic int_clear, powered_up, hs_mode, ref_ready;
  int mismatches = 0;
  int num_checks = 0;
  logic seen_clear = 1'b0;
  logic [7:0] mon_data [0:15];
  logic [3:0] mon_ix [0:15];
  int mon_cnt = 0;

  always #50 sys_clk = ~sys_clk;
  // Pull-up: wire is high unless someone pulls it low
  assign sda = ~((sda_oe & ~sda_out) | sda_low);

  adc_config_write_control #(.REF_WAKE_CYCLES(20)) adc_config_write_control_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(1'b1), .scl_clk(scl), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .conv_done(conv_done),
    .conv_plan(conv_plan), .setup_reg(setup_reg), .mon_write(mon_write),
    .int_clear(int_clear), .powered_up(powered_up), .hs_mode(hs_mode), .ref_ready(ref_ready));
  bus_master_model bus_master_model_inst (.scl(scl), .sda_low(sda_low), .sda(sda));

  // ----------------------------------------
  // Observers of one-cycle pulses
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (int_clear === 1'b1) seen_clear <= 1'b1;
    if (mon_write.valid === 1'b1) begin
      mon_data[mon_cnt] <= mon_write.data;
      mon_ix[mon_cnt] <= mon_write.index;
      mon_cnt <= mon_cnt + 1;
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic ok, input string msg);
    @(negedge sys_clk);
    num_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task automatic xfer(input logic [7:0] b, input logic exp_ack);
    logic a;
    bus_master_model_inst.write_byte(b, a);
    check(a === exp_ack, "ack bit");
  endtask

  task automatic pulse_done();
    @(posedge sys_clk);
    conv_done <= 1'b1;
    @(posedge sys_clk);
    conv_done <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  function automatic conv_plan_s plan_of(input logic [7:0] c, input logic [7:0] s);
    conv_plan_s p;
    p.mode = scan_mode_e'(c[6:5]);
    p.first_channel = c[5] ? c[2:1] : 2'h0;
    p.last_channel = c[2:1];
    p.repeat_count = (c[6:5] == 2'h1) ? 4'h8 : 4'h1;
    p.readback_enable = c[4] & c[3];
    p.single_ended = c[0];
    p.unipolar = c[0] | ~s[2];
    p.external_clock = s[3];
    return p;
  endfunction

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    check(setup_reg === 8'h82 && conv_plan === plan_of(8'h01, 8'h82), "reset values");
    check(powered_up === 1'b0 && hs_mode === 1'b0, "reset levels");
    $display("test reset done");
  endtask

  task automatic t_config();
    logic [7:0] cfgs [4] = '{8'h07, 8'h23, 8'h44, 8'h7b};
    bus_master_model_inst.bus_start();
    xfer(8'h68, 1'b1);
    check(powered_up === 1'b1, "power up on address");
    foreach (cfgs[i]) begin
      xfer(cfgs[i], 1'b1);
      check(conv_plan === plan_of(cfgs[i], 8'h82), "config decode");
    end
    bus_master_model_inst.bus_stop();
    check(powered_up === 1'b1, "internal clock ignores stop");
    pulse_done();
    check(powered_up === 1'b0, "power down on done");
    $display("test config done");
  endtask

  task automatic t_setup();
    bus_master_model_inst.bus_start();
    xfer(8'h68, 1'b1);
    xfer(8'h44, 1'b1);
    xfer(8'h86, 1'b1);
    check(setup_reg === 8'h86 && conv_plan === plan_of(8'h44, 8'h86), "bipolar diff");
    check(seen_clear === 1'b0, "no clear");
    xfer(8'h45, 1'b1);
    check(conv_plan === plan_of(8'h45, 8'h86), "single-ended unipolar");
    xfer(8'h84, 1'b1);
    check(seen_clear === 1'b1 && setup_reg === 8'h84, "setup reset");
    check(conv_plan === plan_of(8'h01, 8'h84), "config back to default");
    xfer(8'h23, 1'b1);
    check(conv_plan === plan_of(8'h23, 8'h84), "config rewritten");
    xfer(8'h82, 1'b1);
    bus_master_model_inst.bus_stop();
    $display("test setup done");
  endtask

  task automatic t_monitor();
    bus_master_model_inst.bus_start();
    xfer(8'h68, 1'b1);
    xfer(8'h83, 1'b1);
    xfer(8'hc0, 1'b1);
    xfer(8'hc1, 1'b1);
    bus_master_model_inst.bus_stop();
    bus_master_model_inst.bus_start();
    xfer(8'h68, 1'b1);
    xfer(8'h23, 1'b1);
    check(mon_cnt == 2 && conv_plan === plan_of(8'h23, 8'h83), "early end");
    xfer(8'h83, 1'b1);
    for (int i = 0; i < 13; i++) xfer(8'hd0 + i[7:0], 1'b1);
    xfer(8'h07, 1'b1);
    check(mon_cnt == 15 && conv_plan === plan_of(8'h07, 8'h83), "thirteen bytes");
    check(mon_data[0] === 8'hc0 && mon_ix[0] === 4'h0, "early byte zero");
    check(mon_data[1] === 8'hc1 && mon_ix[1] === 4'h1, "early byte one");
    check(setup_reg === 8'h83, "setup kept over monitor bytes");
    for (int i = 0; i < 13; i++)
      check(mon_data[i + 2] === 8'hd0 + i[7:0] && mon_ix[i + 2] === i[3:0], "mon byte");
    bus_master_model_inst.bus_stop();
    $display("test monitor done");
  endtask

  task automatic t_hs();
    bus_master_model_inst.bus_start();
    xfer(8'h08, 1'b0);
    check(hs_mode === 1'b1, "high speed on");
    bus_master_model_inst.bus_start();
    xfer(8'h68, 1'b1);
    check(hs_mode === 1'b1, "repeated start keeps mode");
    bus_master_model_inst.bus_stop();
    check(hs_mode === 1'b0, "stop ends high speed");
    $display("test high speed done");
  endtask

  task automatic t_ext();
    bus_master_model_inst.bus_start();
    xfer(8'h68, 1'b1);
    xfer(8'h8a, 1'b1);
    bus_master_model_inst.bus_stop();
    check(powered_up === 1'b0, "ext clock stop");
    bus_master_model_inst.bus_start();
    xfer(8'h68, 1'b1);
    pulse_done();
    check(powered_up === 1'b1, "ext clock ignores done");
    bus_master_model_inst.bus_stop();
    check(powered_up === 1'b0, "ext clock second stop");
    bus_master_model_inst.bus_start();
    xfer(8'h69, 1'b1);
    check(powered_up === 1'b1, "read address wakes");
    xfer(8'hff, 1'b0);
    check(powered_up === 1'b0, "ext clock nack");
    bus_master_model_inst.bus_stop();
    $display("test external clock done");
  endtask

  task automatic t_ref();
    bus_master_model_inst.bus_start();
    xfer(8'h68, 1'b1);
    xfer(8'hd2, 1'b1);
    bus_master_model_inst.bus_stop();
    repeat (40) @(posedge sys_clk);
    check(ref_ready === 1'b1, "reference ready");
    bus_master_model_inst.bus_start();
    xfer(8'h68, 1'b1);
    xfer(8'h82, 1'b1);
    bus_master_model_inst.bus_stop();
    check(ref_ready === 1'b0, "reference off");
    bus_master_model_inst.bus_start();
    xfer(8'h6a, 1'b0);
    xfer(8'h05, 1'b0);
    bus_master_model_inst.bus_stop();
    check(conv_plan === plan_of(8'h07, 8'h82), "other address ignored");
    $display("test reference and address done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    t_reset();
    t_config();
    t_setup();
    t_monitor();
    t_hs();
    t_ext();
    t_ref();
    end_of_test();
  end

  // Whole sequence is about 46 bytes of some 11 us each
  initial begin
    #3000000;
    mismatches++;
    end_of_test();
  end
endmodule // tb_adc_config_write_control

`default_nettype wire
